//--- hw/hbmsp_port.sv
// Host bus port: slave register access, DMA master cycles, arbitration and interrupt pins.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module hbmsp_port (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [hbmsp_pkg::REG_AW-1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   input wire logic [hbmsp_pkg::NUM_FLAGS-1:0] i_evt_flags,
   input wire logic [31:0] i_addr_data_lines,
   output logic [31:0] o_addr_data_lines,
   output logic o_addr_data_lines_oe,
   input wire logic i_addr_strobe,
   output logic o_addr_strobe,
   output logic o_addr_strobe_oe,
   input wire logic i_data_phase_strobe,
   output logic o_data_phase_strobe,
   output logic o_data_phase_strobe_oe,
   input wire logic i_direction,
   output logic o_direction,
   output logic o_direction_oe,
   input wire logic i_register_select,
   input wire logic i_control_data_sel,
   input wire logic i_target_ack_wait,
   output logic o_target_ack_wait_oe,
   input wire logic i_hold_ack,
   output logic o_bus_request_x86_oe,
   output logic o_owner_x86_oe,
   input wire logic i_bus_grant_68k,
   output logic o_bus_request_68k_oe,
   input wire logic i_grant_ack_68k,
   output logic o_grant_ack_68k_oe,
   output logic o_xcvr_in_enable,
   output logic o_xcvr_out_enable,
   output logic o_interrupt_summary_oe,
   output logic o_rx_irq_oe
);
   import hbmsp_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      hbmsp_st_e st;
      logic init;
      logic pol;
      logic [1:0] style;
      logic rxmask;
      logic ie;
      logic [NUM_FLAGS-1:0] flags;
      logic [31:0] dma_addr;
      logic [31:0] dma_wdata;
      logic [31:0] dma_rdata;
      logic dma_read;
      logic [3:0] lanes;
      logic pend;
      logic [7:0] rap;
      logic [2:0] wcnt;
      logic [31:0] rdata;
      logic [31:0] ad;
      logic ad_oe;
      logic astrb;
      logic astrb_oe;
      logic dps;
      logic dps_oe;
      logic dir;
      logic dir_oe;
      logic taw_oe;
      logic req86_oe;
      logic own86_oe;
      logic req68_oe;
      logic gack_oe;
      logic xin;
      logic xout;
      logic irq_sum_oe;
      logic rx_irq_oe;
   } hbmsp_state_s;

   hbmsp_state_s q;
   hbmsp_state_s d;

   logic [PIN_W-1:0] pin_vec;
   logic [PIN_W-1:0] s;
   logic astrb_act;
   logic slave_hit;

   assign pin_vec = {i_grant_ack_68k, i_bus_grant_68k, i_hold_ack, i_target_ack_wait, i_control_data_sel,
                     i_register_select, i_direction, i_data_phase_strobe, i_addr_strobe, i_addr_data_lines};
   assign s = q.sync2;
   // Strobe is active high when polarity is 0 and active low when it is 1.
   assign astrb_act = s[PIN_ASTRB] ^ q.pol;
   assign slave_hit = q.init && s[PIN_RSEL] && s[PIN_DPS];

   function automatic logic [31:0] reg_read(input hbmsp_state_s r, input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      case (a)
         OFS_CTRL: begin
            v[CTRL_INIT] = r.init;
            v[CTRL_POL] = r.pol;
            v[CTRL_STYLE +: 2] = r.style;
            v[CTRL_RXMASK] = r.rxmask;
         end
         OFS_STATUS: begin
            for (int k = 0; k < NUM_FLAGS; k++) begin
               v[FLAG_POS[k]] = r.flags[k];
            end
            v[STAT_IE] = r.ie;
            v[STAT_SUM] = (|r.flags[FLG_RX-1:0]) | (r.flags[FLG_RX] & ~r.rxmask);
            v[STAT_OWNER] = r.own86_oe | r.gack_oe;
         end
         OFS_DMA_ADDR: v = r.dma_addr;
         OFS_DMA_WDATA: v = r.dma_wdata;
         OFS_DMA_RDATA: v = r.dma_rdata;
         OFS_DMA_CMD: begin
            v[CMD_BUSY] = r.pend;
            v[CMD_READ] = r.dma_read;
            v[CMD_LANE +: 4] = r.lanes;
         end
         default: v = '0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic wen;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [NUM_FLAGS-1:0] clr;
      logic sl_wr;
      logic [31:0] sl_wdata;
      wen = 1'b0;
      waddr = '0;
      wdata = '0;
      clr = '0;
      sl_wr = 1'b0;
      sl_wdata = '0;
      d = q;
      d.sync1 = pin_vec;
      d.sync2 = q.sync1;
      d.rdata = '0;
      if (i_reg_rd) begin
         d.rdata = reg_read(q, i_reg_addr);
      end

      case (q.st)
         ST_IDLE: begin
            if (slave_hit) begin
               d.st = ST_SLAVE;
               d.wcnt = '0;
               d.taw_oe = 1'b1;
            end else if (q.pend && q.init) begin
               d.st = ST_REQ;
            end
         end
         ST_REQ: begin
            if (slave_hit) begin
               d.req86_oe = 1'b0;
               d.req68_oe = 1'b0;
               d.st = ST_SLAVE;
               d.wcnt = '0;
               d.taw_oe = 1'b1;
            end else if (q.style == STYLE_68K) begin
               d.req68_oe = 1'b1;
               if (s[PIN_GRANT] && !s[PIN_GACK] && !s[PIN_DPS] && !astrb_act) begin
                  d.gack_oe = 1'b1;
                  d.req68_oe = 1'b0;
                  d.st = ST_ADDR;
               end
            end else begin
               d.req86_oe = 1'b1;
               if (s[PIN_HOLD] && !astrb_act) begin
                  d.own86_oe = 1'b1;
                  d.st = ST_ADDR;
               end
            end
         end
         ST_ADDR: begin
            d.ad_oe = 1'b1;
            d.ad[31:2] = q.dma_addr[31:2];
            if (q.style == STYLE_X86) begin
               d.ad[1:0] = q.lanes[3:2];
            end else begin
               d.ad[1:0] = q.dma_addr[1:0];
            end
            d.astrb_oe = 1'b1;
            d.astrb = ~q.pol;
            d.dir_oe = 1'b1;
            d.dir = q.dma_read;
            d.xout = 1'b1;
            d.xin = 1'b0;
            d.st = ST_DATA;
         end
         ST_DATA: begin
            d.astrb = q.pol;
            d.dps_oe = 1'b1;
            d.dps = 1'b1;
            if (q.dma_read) begin
               d.ad_oe = 1'b0;
               d.xout = 1'b0;
               d.xin = 1'b1;
            end else begin
               d.ad = q.dma_wdata;
            end
            if (q.dps && s[PIN_TAW]) begin
               if (q.dma_read) begin
                  d.dma_rdata = s[31:0];
               end
               d.pend = 1'b0;
               d.st = ST_REL;
            end
         end
         ST_REL: begin
            d.st = ST_IDLE;
         end
         ST_SLAVE: begin
            d.xin = ~s[PIN_DIR];
            if (32'(q.wcnt) + 1 >= SLAVE_WAIT_CYC) begin
               d.taw_oe = 1'b0;
               d.st = ST_SLAVE_END;
               if (s[PIN_DIR]) begin
                  d.ad_oe = 1'b1;
                  d.xout = 1'b1;
                  d.xin = 1'b0;
                  d.ad = s[PIN_CDSEL] ? {24'h000000, q.rap} : reg_read(q, q.rap);
               end else if (s[PIN_CDSEL]) begin
                  d.rap = s[7:0];
               end else begin
                  sl_wr = 1'b1;
                  sl_wdata = s[31:0];
               end
            end else begin
               d.wcnt = q.wcnt + 3'h1;
            end
         end
         ST_SLAVE_END: begin
            if (!s[PIN_DPS] || !s[PIN_RSEL]) begin
               d.ad_oe = 1'b0;
               d.xin = 1'b0;
               d.xout = 1'b0;
               d.st = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase

      // A withdrawn hold_ack aborts the transfer; the command stays pending for a retry.
      if (q.style == STYLE_X86 && q.own86_oe && !s[PIN_HOLD]) begin
         d.st = ST_REL;
      end
      if (d.st == ST_REL) begin
         d.ad_oe = 1'b0;
         d.astrb_oe = 1'b0;
         d.dps_oe = 1'b0;
         d.dps = 1'b0;
         d.dir_oe = 1'b0;
         d.xin = 1'b0;
         d.xout = 1'b0;
         d.req86_oe = 1'b0;
         d.own86_oe = 1'b0;
         d.gack_oe = 1'b0;
      end

      if (i_reg_wr) begin
         wen = 1'b1;
         waddr = i_reg_addr;
         wdata = i_reg_wdata;
      end else if (sl_wr) begin
         wen = 1'b1;
         waddr = q.rap;
         wdata = sl_wdata;
      end
      if (wen) begin
         case (waddr)
            OFS_CTRL: begin
               d.init = q.init | wdata[CTRL_INIT];
               d.pol = wdata[CTRL_POL];
               d.style = wdata[CTRL_STYLE +: 2];
               d.rxmask = wdata[CTRL_RXMASK];
            end
            OFS_STATUS: begin
               d.ie = wdata[STAT_IE];
               for (int k = 0; k < NUM_FLAGS; k++) begin
                  clr[k] = wdata[FLAG_POS[k]];
               end
            end
            OFS_DMA_ADDR: d.dma_addr = wdata;
            OFS_DMA_WDATA: d.dma_wdata = wdata;
            OFS_DMA_CMD: begin
               if (wdata[CMD_START] && !q.pend) begin
                  d.pend = 1'b1;
                  d.dma_read = wdata[CMD_READ];
                  d.lanes = wdata[CMD_LANE +: 4];
               end
            end
            default: d.pend = d.pend;
         endcase
      end
      // A new event wins over a clear written in the same cycle.
      d.flags = (q.flags & ~clr) | i_evt_flags;
      d.irq_sum_oe = q.ie && (|q.flags[FLG_RX-1:0]);
      d.rx_irq_oe = q.ie && q.flags[FLG_RX] && !q.rxmask;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_reg_rdata = q.rdata;
   assign o_addr_data_lines = q.ad;
   assign o_addr_data_lines_oe = q.ad_oe;
   assign o_addr_strobe = q.astrb;
   assign o_addr_strobe_oe = q.astrb_oe;
   assign o_data_phase_strobe = q.dps;
   assign o_data_phase_strobe_oe = q.dps_oe;
   assign o_direction = q.dir;
   assign o_direction_oe = q.dir_oe;
   assign o_target_ack_wait_oe = q.taw_oe;
   assign o_bus_request_x86_oe = q.req86_oe;
   assign o_owner_x86_oe = q.own86_oe;
   assign o_bus_request_68k_oe = q.req68_oe;
   assign o_grant_ack_68k_oe = q.gack_oe;
   assign o_xcvr_in_enable = q.xin;
   assign o_xcvr_out_enable = q.xout;
   assign o_interrupt_summary_oe = q.irq_sum_oe;
   assign o_rx_irq_oe = q.rx_irq_oe;

   localparam int PRE_LIM = 5;
   logic [2:0] pre_cnt_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_cnt_q <= '0;
      end else if (o_owner_x86_oe && !i_hold_ack && pre_cnt_q != 3'h7) begin
         pre_cnt_q <= pre_cnt_q + 3'h1;
      end else if (!(o_owner_x86_oe && !i_hold_ack)) begin
         pre_cnt_q <= '0;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   property p_strobe_edge;
      $rose(o_data_phase_strobe) |-> o_addr_strobe == q.pol && $past(o_addr_strobe) == !q.pol;
   endproperty
   a_strobe_edge: assert property (p_strobe_edge) else $error("address strobe polarity wrong");

   property p_own_needs_idle_strobe;
      $rose(o_owner_x86_oe) |-> !$past(astrb_act) && $past(s[PIN_HOLD]);
   endproperty
   a_own_needs_idle_strobe: assert property (p_own_needs_idle_strobe) else $error("owner taken early");

   property p_gack_entry;
      $rose(o_grant_ack_68k_oe) |-> $past(s[PIN_GRANT]) && !$past(s[PIN_GACK]) && !$past(s[PIN_DPS]);
   endproperty
   a_gack_entry: assert property (p_gack_entry) else $error("grant ack without idle bus");

   property p_gack_held;
      (q.style == STYLE_68K && o_data_phase_strobe_oe) |-> o_grant_ack_68k_oe;
   endproperty
   a_gack_held: assert property (p_gack_held) else $error("grant ack dropped while owner");

   property p_lane_bits;
      $rose(o_addr_strobe_oe) |-> o_addr_data_lines[1:0] ==
         (q.style == STYLE_X86 ? q.lanes[3:2] : q.dma_addr[1:0]) && o_addr_data_lines[31:2] == q.dma_addr[31:2];
   endproperty
   a_lane_bits: assert property (p_lane_bits) else $error("address phase low bits wrong");

   property p_preempt;
      pre_cnt_q <= PRE_LIM;
   endproperty
   a_preempt: assert property (p_preempt) else $error("request held after preemption");

   property p_summary;
      (q.ie && |i_evt_flags[FLG_RX-1:0]) ##1 q.ie |=> o_interrupt_summary_oe;
   endproperty
   a_summary: assert property (p_summary) else $error("summary pin missed an event");

   property p_rx_only;
      (q.flags[FLG_RX-1:0] == '0) [*2] |-> !o_interrupt_summary_oe;
   endproperty
   a_rx_only: assert property (p_rx_only) else $error("summary pin driven without cause");

   property p_rx_pin;
      (q.flags[FLG_RX] && q.ie && !q.rxmask) [*2] |-> o_rx_irq_oe;
   endproperty
   a_rx_pin: assert property (p_rx_pin) else $error("receive pin not asserted");

   property p_slave_entry;
      $rose(o_target_ack_wait_oe) |-> $past(s[PIN_RSEL]) && $past(s[PIN_DPS]) && !$past(o_data_phase_strobe_oe);
   endproperty
   a_slave_entry: assert property (p_slave_entry) else $error("slave cycle without select");

   property p_reset_float;
      !q.init |-> !(o_addr_data_lines_oe || o_addr_strobe_oe || o_data_phase_strobe_oe || o_direction_oe ||
                    o_target_ack_wait_oe || o_bus_request_x86_oe || o_bus_request_68k_oe);
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("bus output driven before init");

   property p_xcvr;
      !(o_xcvr_in_enable && o_xcvr_out_enable);
   endproperty
   a_xcvr: assert property (p_xcvr) else $error("both transceiver enables on");

   c_grant_68k: cover property ($rose(o_grant_ack_68k_oe));
   c_x86_done: cover property (o_owner_x86_oe ##1 !o_owner_x86_oe && !q.pend);
   c_preempt: cover property (o_owner_x86_oe && !i_hold_ack);
   c_slave_read: cover property ($rose(o_addr_data_lines_oe) && q.st == ST_SLAVE_END);

endmodule

//--- hw/hbmsp_pkg.sv
// Constants, register map and state type of the host bus master/slave port.
package hbmsp_pkg;

   localparam int CLK_PERIOD_NS = 100;
   localparam int SLAVE_WAIT_NS = 200;
   localparam int SLAVE_WAIT_CYC = (SLAVE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PREEMPT_MAX_CYC = 5;

   localparam int REG_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DMA_ADDR = 8'h08;
   localparam logic [7:0] OFS_DMA_WDATA = 8'h0C;
   localparam logic [7:0] OFS_DMA_RDATA = 8'h10;
   localparam logic [7:0] OFS_DMA_CMD = 8'h14;

   localparam int CTRL_INIT = 0;
   localparam int CTRL_POL = 1;
   localparam int CTRL_STYLE = 2;
   localparam int CTRL_RXMASK = 7;
   localparam int STAT_IE = 6;
   localparam int STAT_SUM = 7;
   localparam int STAT_OWNER = 15;
   localparam int CMD_START = 0;
   localparam int CMD_READ = 1;
   localparam int CMD_LANE = 4;
   localparam int CMD_BUSY = 0;

   // Flag order: babble, memory error, dropped frame, tx done, init done, tx start, loopback, rx done.
   localparam int NUM_FLAGS = 8;
   localparam int FLG_RX = 7;
   localparam int FLAG_POS [NUM_FLAGS] = '{14, 11, 12, 9, 8, 3, 2, 10};

   localparam logic [1:0] STYLE_X86 = 2'h0;
   localparam logic [1:0] STYLE_68K = 2'h1;

   localparam int PIN_W = 41;
   localparam int PIN_ASTRB = 32;
   localparam int PIN_DPS = 33;
   localparam int PIN_DIR = 34;
   localparam int PIN_RSEL = 35;
   localparam int PIN_CDSEL = 36;
   localparam int PIN_TAW = 37;
   localparam int PIN_HOLD = 38;
   localparam int PIN_GRANT = 39;
   localparam int PIN_GACK = 40;

   typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_REL, ST_SLAVE, ST_SLAVE_END} hbmsp_st_e;

endpackage

//--- sim/hbmsp_mem_model.sv
// Host arbiter and target memory that answer the port's DMA master cycles.
`timescale 1ns/1ns
module hbmsp_mem_model #(
   parameter logic [31:0] MEM_WORD = 32'hC3A5_5A3C
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_req_x86,
   input wire logic i_req_68k,
   input wire logic i_preempt,
   input wire logic i_dps,
   input wire logic i_rd,
   input wire logic [3:0] i_lat,
   output logic o_hold_ack,
   output logic o_grant,
   output logic o_ack,
   output logic o_drive,
   output logic [31:0] o_rdata
);
   logic [3:0] wait_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hold_ack <= 1'b0;
         o_grant <= 1'b0;
         o_ack <= 1'b0;
         wait_q <= 4'h0;
      end else begin
         // The host gives the bus up a cycle after a request and takes it back when preempting.
         o_hold_ack <= i_req_x86 & ~i_preempt;
         // The grant answers a pending request.
         o_grant <= i_req_68k;
         wait_q <= i_dps ? wait_q + 4'h1 : 4'h0;
         // Memory acknowledges only after the chosen number of data strobe cycles.
         o_ack <= i_dps && wait_q >= i_lat;
      end
   end
   // Read data stand on the lines only while the acknowledge marks them valid.
   assign o_drive = o_ack & i_dps & i_rd;
   assign o_rdata = MEM_WORD;
endmodule

//--- sim/test_host_bus_master_slave_port.sv
// Self-checking bench for the host bus port against a host and memory model.
`timescale 1ns/1ns
module test_host_bus_master_slave_port;
   import hbmsp_pkg::*;
   localparam logic [31:0] MEM_WORD = 32'hC3A5_5A3C;
   logic i_sys_clk, i_rst, i_reg_wr, i_reg_rd, i_register_select, i_control_data_sel;
   logic [REG_AW-1:0] i_reg_addr;
   logic [31:0] i_reg_wdata, o_reg_rdata, i_addr_data_lines, o_addr_data_lines, host_ad, mem_rdata;
   logic [NUM_FLAGS-1:0] i_evt_flags;
   logic o_addr_data_lines_oe, i_addr_strobe, o_addr_strobe, o_addr_strobe_oe;
   logic i_data_phase_strobe, o_data_phase_strobe, o_data_phase_strobe_oe;
   logic i_direction, o_direction, o_direction_oe, i_target_ack_wait, o_target_ack_wait_oe;
   logic i_hold_ack, o_bus_request_x86_oe, o_owner_x86_oe, i_bus_grant_68k, o_bus_request_68k_oe;
   logic i_grant_ack_68k, o_grant_ack_68k_oe, o_xcvr_in_enable, o_xcvr_out_enable;
   logic o_interrupt_summary_oe, o_rx_irq_oe;
   logic host_as, host_dps, host_dir, host_ad_drv, other_gack, preempt, mem_ack, mem_drive, idle_bit;
   logic [3:0] mem_lat;
   int num_errors, checks;
   // A line nobody drives shows a level that changes every cycle.
   assign i_addr_data_lines = o_addr_data_lines_oe ? o_addr_data_lines : mem_drive ? mem_rdata :
      host_ad_drv ? host_ad : {32{idle_bit}};
   assign i_addr_strobe = o_addr_strobe_oe ? o_addr_strobe : host_as;
   assign i_data_phase_strobe = o_data_phase_strobe_oe ? o_data_phase_strobe : host_dps;
   assign i_direction = o_direction_oe ? o_direction : host_dir;
   assign i_target_ack_wait = o_target_ack_wait_oe | mem_ack;
   assign i_grant_ack_68k = o_grant_ack_68k_oe | other_gack;
   hbmsp_port hbmsp_port_inst (.*);
   hbmsp_mem_model #(.MEM_WORD(MEM_WORD)) hbmsp_mem_model_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_req_x86(o_bus_request_x86_oe), .i_req_68k(o_bus_request_68k_oe), .i_preempt(preempt),
      .i_dps(o_data_phase_strobe_oe & o_data_phase_strobe), .i_rd(o_direction), .i_lat(mem_lat),
      .o_hold_ack(i_hold_ack), .o_grant(i_bus_grant_68k), .o_ack(mem_ack), .o_drive(mem_drive),
      .o_rdata(mem_rdata));
   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) idle_bit <= ~idle_bit;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_sys_clk);
      v = o_reg_rdata;
   endtask
   task automatic wait_idle();
      logic [31:0] v;
      int n;
      v = 32'h1;
      for (n = 0; n < 40 && v[CMD_BUSY] !== 1'b0; n++) rd(OFS_DMA_CMD, v);
      chk({31'h0, v[CMD_BUSY]}, 32'h0);
   endtask
   task automatic t_reset();
      logic [31:0] v;
      rd(OFS_CTRL, v);
      chk(v, 32'h0);
      rd(OFS_STATUS, v);
      chk(v, 32'h0);
      rd(8'h1C, v);
      chk(v, 32'h0);
      wr(OFS_DMA_CMD, 32'h1);
      repeat (10) @(negedge i_sys_clk);
      chk({o_bus_request_x86_oe, o_addr_data_lines_oe, o_addr_strobe_oe, o_xcvr_out_enable}, 32'h0);
      wr(OFS_CTRL, 32'h1);
      wait_idle();
   endtask
   task automatic t_irq();
      logic [31:0] v;
      int i;
      wr(OFS_STATUS, 32'h40);
      for (i = 0; i < NUM_FLAGS; i++) begin
         @(posedge i_sys_clk);
         i_evt_flags <= 8'h01 << i;
         @(posedge i_sys_clk);
         i_evt_flags <= 8'h00;
         repeat (3) @(negedge i_sys_clk);
         chk({o_interrupt_summary_oe, o_rx_irq_oe}, i == FLG_RX ? 32'h1 : 32'h2);
         rd(OFS_STATUS, v);
         chk({31'h0, v[STAT_SUM]}, 32'h1);
         if (i == FLG_RX) begin
            wr(OFS_CTRL, 32'h81);
            repeat (3) @(negedge i_sys_clk);
            chk({31'h0, o_rx_irq_oe}, 32'h0);
            rd(OFS_STATUS, v);
            chk({31'h0, v[STAT_SUM]}, 32'h0);
            wr(OFS_CTRL, 32'h1);
            wr(OFS_STATUS, 32'h0);
            repeat (3) @(negedge i_sys_clk);
            chk({o_interrupt_summary_oe, o_rx_irq_oe}, 32'h0);
         end
         wr(OFS_STATUS, 32'h40 | (32'h1 << FLAG_POS[i]));
         repeat (3) @(negedge i_sys_clk);
         chk({o_interrupt_summary_oe, o_rx_irq_oe}, 32'h0);
      end
   endtask
   task automatic xfer(input logic [1:0] sty, input logic pol, input logic rdn, input logic [31:0] a,
      input logic [3:0] ln, input logic [31:0] d, input logic [3:0] lat);
      logic [31:0] v;
      int n;
      mem_lat <= lat;
      host_as <= pol;
      wr(OFS_CTRL, {28'h0, sty, pol, 1'b1});
      wr(OFS_DMA_ADDR, a);
      wr(OFS_DMA_WDATA, d);
      wr(OFS_DMA_CMD, {24'h0, ln, 2'h0, rdn, 1'b1});
      // Another master still seems busy, so the port must hold off.
      if (sty == STYLE_X86) host_as <= ~pol;
      else other_gack <= 1'b1;
      repeat (12) @(negedge i_sys_clk);
      chk({o_owner_x86_oe, o_grant_ack_68k_oe, o_addr_data_lines_oe}, 32'h0);
      chk({31'h0, sty == STYLE_X86 ? o_bus_request_x86_oe : o_bus_request_68k_oe}, 32'h1);
      @(posedge i_sys_clk);
      host_as <= pol;
      other_gack <= 1'b0;
      for (n = 0; n < 40 && o_addr_strobe_oe !== 1'b1; n++) @(negedge i_sys_clk);
      chk(o_addr_data_lines, {a[31:2], sty == STYLE_X86 ? ln[3:2] : a[1:0]});
      chk({o_addr_strobe, o_direction_oe, o_direction, o_xcvr_out_enable}, {28'h0, ~pol, 1'b1, rdn, 1'b1});
      chk({31'h0, sty == STYLE_X86 ? o_owner_x86_oe : o_grant_ack_68k_oe}, 32'h1);
      for (n = 0; n < 10 && o_data_phase_strobe !== 1'b1; n++) @(negedge i_sys_clk);
      chk({o_addr_strobe, o_data_phase_strobe_oe, o_xcvr_in_enable, o_xcvr_out_enable},
         {28'h0, pol, 1'b1, rdn, ~rdn});
      if (!rdn) chk(o_addr_data_lines, d);
      else chk({31'h0, o_addr_data_lines_oe}, 32'h0);
      for (n = 0; n < 40 && o_data_phase_strobe === 1'b1; n++) @(negedge i_sys_clk);
      chk({31'h0, n > lat}, 32'h1);
      @(negedge i_sys_clk);
      chk({o_addr_data_lines_oe, o_owner_x86_oe, o_grant_ack_68k_oe, o_bus_request_68k_oe}, 32'h0);
      if (rdn) begin
         rd(OFS_DMA_RDATA, v);
         chk(v, MEM_WORD);
      end
      wait_idle();
   endtask
   task automatic t_preempt();
      int n;
      mem_lat <= 4'h8;
      host_as <= 1'b0;
      wr(OFS_CTRL, 32'h1);
      wr(OFS_DMA_CMD, 32'h1);
      for (n = 0; n < 40 && o_data_phase_strobe !== 1'b1; n++) @(negedge i_sys_clk);
      @(posedge i_sys_clk);
      preempt <= 1'b1;
      for (n = 0; n < 10 && i_hold_ack !== 1'b0; n++) @(negedge i_sys_clk);
      for (n = 0; n < 10 && o_bus_request_x86_oe !== 1'b0; n++) @(negedge i_sys_clk);
      chk({31'h0, n <= PREEMPT_MAX_CYC}, 32'h1);
      @(posedge i_sys_clk);
      preempt <= 1'b0;
      wait_idle();
   endtask
   task automatic scyc(input logic sel, input logic cd, input logic rdn, input logic [31:0] d,
      output logic [31:0] got);
      int n;
      int w;
      w = 0;
      @(posedge i_sys_clk);
      i_register_select <= sel;
      i_control_data_sel <= cd;
      host_dir <= rdn;
      host_ad <= d;
      host_ad_drv <= ~rdn;
      host_dps <= 1'b1;
      for (n = 0; n < 20 && (w == 0 || o_target_ack_wait_oe === 1'b1); n++) begin
         @(negedge i_sys_clk);
         if (o_target_ack_wait_oe === 1'b1) w++;
      end
      got = o_addr_data_lines;
      chk(w, sel ? SLAVE_WAIT_CYC : 0);
      if (sel && rdn) chk({31'h0, o_xcvr_out_enable}, 32'h1);
      @(posedge i_sys_clk);
      i_register_select <= 1'b0;
      host_dps <= 1'b0;
      host_ad_drv <= 1'b0;
      repeat (4) @(negedge i_sys_clk);
   endtask
   task automatic t_slave();
      logic [31:0] v;
      scyc(1'b1, 1'b1, 1'b0, {24'h0, OFS_STATUS}, v);
      scyc(1'b1, 1'b0, 1'b1, 32'h0, v);
      chk(v, 32'h40);
      scyc(1'b1, 1'b1, 1'b1, 32'h0, v);
      chk({24'h0, v[7:0]}, {24'h0, OFS_STATUS});
      scyc(1'b1, 1'b0, 1'b0, 32'h0, v);
      rd(OFS_STATUS, v);
      chk(v, 32'h0);
      scyc(1'b0, 1'b0, 1'b1, 32'h0, v);
   endtask
   task automatic test_done();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #3000000;
      num_errors++;
      test_done();
   end
   initial begin
      i_rst = 1'b1;
      {i_reg_wr, i_reg_rd, i_register_select, i_control_data_sel, idle_bit} = '0;
      {host_as, host_dps, host_dir, host_ad_drv, other_gack, preempt} = '0;
      i_reg_addr = '0;
      i_reg_wdata = '0;
      i_evt_flags = '0;
      host_ad = '0;
      mem_lat = '0;
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_reset();
      t_irq();
      xfer(STYLE_X86, 1'b0, 1'b0, 32'h1234_5679, 4'hA, 32'hDEAD_BEEF, 4'h0);
      xfer(STYLE_X86, 1'b0, 1'b1, 32'h8000_0004, 4'h5, 32'h0, 4'h3);
      xfer(STYLE_68K, 1'b1, 1'b0, 32'h0F0F_F0F2, 4'h0, 32'h5555_AAAA, 4'h1);
      xfer(STYLE_68K, 1'b1, 1'b1, 32'hFFFF_FFFF, 4'h0, 32'h0, 4'h6);
      t_preempt();
      t_slave();
      test_done();
   end
endmodule
